// File: common/adcsp_params.svh
`ifndef ADCSP_PARAMS_SVH
`define ADCSP_PARAMS_SVH
// Notes on behaviour
// - each result bit goes out on a serial clock falling edge, one per period
// - wide variant frame: two zeros, channel bit, mode bit, 12 result bits MSB first
// - narrow variant frame: two zeros, channel, mode, 10 result bits, two trailing zeros
// - active-low select starts a conversion and frames the transfer
// - the serial clock alone advances the conversion and the shifting
// - host drives channel choice on data-in, captured on falling clock edges
// - third data-in bit of a frame selects the input channel
// - sample cycle is setup, 12.5 clock periods, then acquisition
// - conversion takes 16 clock periods wide, 14 narrow; clock up to 18 MHz
// - fourth frame bit shows normal or daisy-chain mode
// - sampling stage returns to tracking at the end of each conversion
// - output driven only after select, released after the final falling edge

// ****************************************
// variants and frame layout
// ****************************************
`define ADCSP_RES_WIDE 12
`define ADCSP_RES_BITS_DEF 12
`define ADCSP_CONV_CLKS_WIDE 5'd16
`define ADCSP_CONV_CLKS_NARROW 5'd14
`define ADCSP_FRAME_BITS 5'd16
`define ADCSP_CHAN_BIT 5'd2
`define ADCSP_MODE_BIT 5'd3
`define ADCSP_CHAN_EDGE 5'd3
`define ADCSP_DATA_START 5'd4

// ****************************************
// pin order in the synchroniser vector
// ****************************************
`define ADCSP_PIN_CS 2
`define ADCSP_PIN_SCLK 1
`define ADCSP_PIN_DIN 0
`define ADCSP_PIN_IDLE 3'h6
`define ADCSP_CNT_ZERO 5'h00
`endif

// File: common/adcsp_pkg.sv
package adcsp_pkg;
  typedef enum logic {ADCSP_NORMAL, ADCSP_CHAIN} adcsp_mode_t;
  typedef enum logic [0:0] {ADCSP_IDLE, ADCSP_FRAME} adcsp_state_t;
endpackage

// File: verilog/adcsp_pair_buf.sv
`timescale 1ns/1ps
module adcsp_pair_buf #(
  parameter int WIDTH = 13
) (
  input wire logic sys_clk_i,               // system clock
  input wire logic reset_i,                 // synchronous reset
  input wire logic in_valid_i,              // word offered
  output logic in_ready_o,                  // room for a word
  input wire logic [WIDTH-1:0] in_data_i,   // word in
  output logic out_valid_o,                 // word available
  input wire logic out_ready_i,             // consumer takes word
  output logic [WIDTH-1:0] out_data_o       // word out
);
  import adcsp_pkg::*;

  logic [WIDTH-1:0] tail_reg;
  wire push = in_valid_i & in_ready_o;
  wire pop = out_valid_o & out_ready_i;

  // head is the output register so the data port comes straight from a flop;
  // the room flag is a flop too: high while the tail entry is empty
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      out_valid_o <= 1'b0;
      out_data_o <= '0;
      in_ready_o <= 1'b1;
      tail_reg <= '0;
    end else begin
      if (pop) begin
        out_data_o <= in_ready_o ? in_data_i : tail_reg;
        out_valid_o <= ~in_ready_o | push;
      end else if (!out_valid_o && push) begin
        out_data_o <= in_data_i;
        out_valid_o <= 1'b1;
      end
      if (push && out_valid_o && !pop) begin
        tail_reg <= in_data_i;
        in_ready_o <= 1'b0;
      end else if (pop) begin
        in_ready_o <= 1'b1;
      end
    end
  end
endmodule

// File: verilog/adcsp_serial_port.sv
`timescale 1ns/1ps
`include "adcsp_params.svh"
module adcsp_serial_port #(
  parameter int RES_BITS = `ADCSP_RES_BITS_DEF
) (
  input wire logic sys_clk_i,                        // 125 MHz system clock
  input wire logic reset_i,                          // synchronous, active high
  input wire logic cs_n_i,                           // chip select pin, active low
  input wire logic sclk_i,                           // serial clock pin
  input wire logic din_i,                            // serial data-in pin
  output logic dout_o,                               // serial data-out level
  output logic dout_oe_o,                            // data-out drive enable
  input wire adcsp_pkg::adcsp_mode_t chain_mode_i,   // normal or daisy-chain
  input wire logic cmp_above_i,                      // comparator: input >= trial code
  output logic [RES_BITS-1:0] dac_code_o,            // trial code to the comparator
  output logic track_o,                              // 1 = track, 0 = hold
  output logic chan_sel_o,                           // analog mux select
  output logic result_valid_o,                       // buffered result present
  input wire logic result_ready_i,                   // consumer takes result
  output logic [RES_BITS-1:0] result_data_o,         // buffered result word
  output logic result_chan_o,                        // channel of that result
  output logic buf_ready_o,                          // buffer can take a word
  output logic overrun_o                             // pulse: result dropped
);
  import adcsp_pkg::*;

  localparam int PW = $clog2(RES_BITS);
  localparam logic [4:0] CONV_CLKS = (RES_BITS == `ADCSP_RES_WIDE) ?
    `ADCSP_CONV_CLKS_WIDE : `ADCSP_CONV_CLKS_NARROW;
  localparam logic [4:0] LAST_DATA = 5'(`ADCSP_DATA_START + RES_BITS - 1);
  localparam logic [RES_BITS-1:0] DAC_MSB = {1'b1, {(RES_BITS-1){1'b0}}};
  localparam logic [RES_BITS-1:0] DAC_LSB = {{(RES_BITS-1){1'b0}}, 1'b1};

  // ****************************************
  // pin synchronisers and glitch filter
  // ****************************************
  logic [2:0] sync1_reg, sync2_reg, sync3_reg, filt_reg;
  wire [2:0] pin_raw = {cs_n_i, sclk_i, din_i};
  wire [2:0] agree = ~(sync2_reg ^ sync3_reg);
  wire [2:0] filt_next = (sync3_reg & agree) | (filt_reg & ~agree);

  // a level counts once stages two and three agree; sclk must stay two
  // system clocks in each phase, which holds up to the 18 MHz limit
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      sync1_reg <= `ADCSP_PIN_IDLE;
      sync2_reg <= `ADCSP_PIN_IDLE;
      sync3_reg <= `ADCSP_PIN_IDLE;
      filt_reg <= `ADCSP_PIN_IDLE;
    end else begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      filt_reg <= filt_next;
    end
  end

  wire cs_fall = filt_reg[`ADCSP_PIN_CS] & ~filt_next[`ADCSP_PIN_CS];
  wire cs_rise = ~filt_reg[`ADCSP_PIN_CS] & filt_next[`ADCSP_PIN_CS];
  wire sclk_fall = filt_reg[`ADCSP_PIN_SCLK] & ~filt_next[`ADCSP_PIN_SCLK];
  wire din_now = filt_next[`ADCSP_PIN_DIN];

  // ****************************************
  // frame sequencing and decode
  // ****************************************
  adcsp_state_t state_reg;
  logic [4:0] edge_cnt_reg;
  logic [RES_BITS-1:0] dac_reg, word_reg;
  logic [`ADCSP_FRAME_BITS-1:0] din_shift_reg;
  logic dout_reg, dout_oe_reg, track_reg, chan_sel_reg, chan_req_reg, mode_reg;
  logic push_reg, word_chan_reg, overrun_reg;
  logic buf_ready;

  wire in_frame = (state_reg == ADCSP_FRAME);
  wire edge_fall = in_frame & sclk_fall & ~cs_rise;
  wire [4:0] edge_idx = edge_cnt_reg + 5'd1;
  wire is_data = (edge_idx >= `ADCSP_DATA_START) && (edge_idx <= LAST_DATA);
  wire [PW-1:0] bit_pos = PW'(LAST_DATA - edge_idx);
  wire [RES_BITS-1:0] trial_mask = DAC_LSB << bit_pos;
  wire [RES_BITS-1:0] next_mask = trial_mask >> 1;
  // successive approximation: keep or drop the trial bit, then try the next
  wire [RES_BITS-1:0] dac_next = (cmp_above_i ? dac_reg : (dac_reg & ~trial_mask)) |
    next_mask;
  wire frame_bit = (edge_idx == `ADCSP_CHAN_BIT) ? chan_sel_reg :
    (edge_idx == `ADCSP_MODE_BIT) ? mode_reg :
    is_data ? cmp_above_i : 1'b0;
  wire frame_end = edge_fall && (edge_idx == `ADCSP_FRAME_BITS);
  wire conv_end = edge_fall && (edge_idx == CONV_CLKS);
  wire data_done = edge_fall && (edge_idx == LAST_DATA);
  wire chan_edge = edge_fall && (edge_idx == `ADCSP_CHAN_EDGE);

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      state_reg <= ADCSP_IDLE;
      edge_cnt_reg <= `ADCSP_CNT_ZERO;
    end else if (cs_fall) begin
      state_reg <= ADCSP_FRAME;
      edge_cnt_reg <= `ADCSP_CNT_ZERO;
    end else if (cs_rise || frame_end) begin
      state_reg <= ADCSP_IDLE;
    end else if (edge_fall) begin
      edge_cnt_reg <= edge_idx;
    end
  end

  // ****************************************
  // data-out pin
  // ****************************************
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      dout_reg <= 1'b0;
      dout_oe_reg <= 1'b0;
    end else if (cs_fall) begin
      dout_oe_reg <= 1'b1;
      dout_reg <= 1'b0;
    end else if (cs_rise || frame_end) begin
      dout_oe_reg <= 1'b0;
      dout_reg <= 1'b0;
    end else if (edge_fall) begin
      dout_reg <= frame_bit;
    end
  end

  // ****************************************
  // conversion, channel and mode
  // ****************************************
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      track_reg <= 1'b1;
      dac_reg <= '0;
      mode_reg <= 1'b0;
    end else if (cs_fall) begin
      track_reg <= 1'b0;
      dac_reg <= DAC_MSB;
      mode_reg <= (chain_mode_i == ADCSP_CHAIN);
    end else if (cs_rise || conv_end) begin
      track_reg <= 1'b1;
    end else if (edge_fall && is_data) begin
      dac_reg <= dac_next;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      din_shift_reg <= '0;
      chan_req_reg <= 1'b0;
      chan_sel_reg <= 1'b0;
    end else begin
      if (edge_fall) begin
        din_shift_reg <= {din_shift_reg[`ADCSP_FRAME_BITS-2:0], din_now};
      end
      if (chan_edge) begin
        chan_req_reg <= din_now;
      end
      // mux moves only after the frame's channel bit has gone out
      if (conv_end) begin
        chan_sel_reg <= chan_req_reg;
      end
    end
  end

  // ****************************************
  // result hand-off through the pair buffer
  // ****************************************
  // the host clock cannot be stalled, so a word with no room is dropped and
  // flagged rather than held back
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      push_reg <= 1'b0;
      word_reg <= '0;
      word_chan_reg <= 1'b0;
      overrun_reg <= 1'b0;
    end else begin
      push_reg <= data_done;
      overrun_reg <= push_reg & ~buf_ready;
      if (data_done) begin
        word_reg <= dac_next;
        word_chan_reg <= chan_sel_reg;
      end
    end
  end

  adcsp_pair_buf #(.WIDTH(RES_BITS + 1)) u_buf (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .in_valid_i(push_reg),
    .in_ready_o(buf_ready),
    .in_data_i({word_chan_reg, word_reg}),
    .out_valid_o(result_valid_o),
    .out_ready_i(result_ready_i),
    .out_data_o({result_chan_o, result_data_o})
  );

  assign dout_o = dout_reg;
  assign dout_oe_o = dout_oe_reg;
  assign track_o = track_reg;
  assign chan_sel_o = chan_sel_reg;
  assign dac_code_o = dac_reg;
  assign buf_ready_o = buf_ready;
  assign overrun_o = overrun_reg;

  // ****************************************
  // checks
  // ****************************************
  start_drive_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    cs_fall |=> dout_oe_o && !dout_o && !track_o)
    else $error("select did not start frame and sample");
  lead_zero_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    edge_fall && edge_idx == 5'd1 |=> !dout_o ##0 dout_oe_o)
    else $error("second leading bit not zero");
  chan_bit_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    edge_fall && edge_idx == `ADCSP_CHAN_BIT |=> dout_o == chan_sel_o)
    else $error("channel bit differs from converted channel");
  mode_bit_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    edge_fall && edge_idx == `ADCSP_MODE_BIT |=> dout_o == $past(mode_reg))
    else $error("mode bit wrong");
  sar_bit_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    edge_fall && is_data |=> dout_o == $past(cmp_above_i))
    else $error("result bit not the comparator decision");
  tail_zero_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    edge_fall && edge_idx > LAST_DATA && edge_idx < `ADCSP_FRAME_BITS |=> !dout_o)
    else $error("trailing bit not zero");
  hold_shift_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    in_frame && !sclk_fall && !cs_rise && !cs_fall |=> $stable(dout_o))
    else $error("data-out moved without a falling edge");
  release_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    frame_end |=> !dout_oe_o ##1 !dout_oe_o)
    else $error("data-out not released after last edge");
  track_end_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    conv_end |=> track_o && !$past(track_o))
    else $error("no return to tracking at conversion end");
  chan_pick_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    chan_edge |=> chan_req_reg == $past(din_now))
    else $error("third data-in bit not captured as channel");
  capture_din_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    edge_fall |=> din_shift_reg[0] == $past(din_now))
    else $error("data-in bit not captured on falling edge");
endmodule

// File: dv/adcsp_host_model.sv
`timescale 1ns/1ps
module adcsp_host_model (
  input wire logic sys_clk_i, // system clock, pins move on its falling edge
  output logic cs_n_o,        // select, active low
  output logic sclk_o,        // serial clock, idles high between frames
  output logic din_o,         // serial data in
  input wire logic dout_a_i,  // wide variant data out
  input wire logic oe_a_i,    // wide variant drive enable
  input wire logic dout_b_i,  // narrow variant data out
  input wire logic oe_b_i     // narrow variant drive enable
);
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b1;
    din_o = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask

  // ****************************************
  // one frame, nfall below 16 aborts it
  // ****************************************
  // select frames, clock drives all, din on falls
  task automatic frame(input logic [15:0] din_w, input int nfall,
                       output logic [15:0] got_a, output logic [15:0] got_b,
                       output logic oe_ok);
    oe_ok = 1'b1;
    got_a = 16'h0000;
    got_b = 16'h0000;
    cs_n_o = 1'b0;
    for (int k = 0; k < nfall; k++) begin
      din_o = din_w[15-k];
      // phases of 6 cycles leave margin over the 3-flop filter
      wait_clk(6);
      // a released pin reads as the inverse, so a late or early release shows
      got_a[15-k] = oe_a_i ? dout_a_i : ~dout_a_i;
      got_b[15-k] = oe_b_i ? dout_b_i : ~dout_b_i;
      oe_ok = oe_ok & oe_a_i & oe_b_i;
      sclk_o = 1'b0;
      wait_clk(6);
      sclk_o = 1'b1;
    end
    wait_clk(6);
    cs_n_o = 1'b1;
    din_o = ~din_o;
    // quiet gap and acquisition window before the next select
    wait_clk(40);
  endtask
endmodule

// File: dv/adcsp_serial_port_tb_top.sv
`timescale 1ns/1ps
module adcsp_serial_port_tb_top;
  import adcsp_pkg::*;
  logic sys_clk = 1'b0;
  logic reset, cs_n, sclk, din, rdy, prev, ovr_sa = 1'b0, ovr_sb = 1'b0;
  logic dout_a, oe_a, track_a, chan_a, valid_a, rchan_a, bufr_a, ovr_a, cmp_a;
  logic dout_b, oe_b, track_b, chan_b, valid_b, rchan_b, bufr_b, ovr_b, cmp_b;
  logic [11:0] dac_a, data_a, v0, v1;
  logic [9:0] dac_b, data_b;
  logic [11:0] vals [4] = '{12'hFFF, 12'h000, 12'h801, 12'h3C5};
  logic [12:0] exp_w [4];
  adcsp_mode_t mode;
  int n_w, bad_count = 0, total_checks = 0;

  always #4 sys_clk = ~sys_clk;
  // comparator stands in for the analog front end
  assign cmp_a = ((chan_a ? v1 : v0) >= dac_a);
  assign cmp_b = ((chan_b ? v1[11:2] : v0[11:2]) >= dac_b);
  always @(posedge sys_clk) begin
    if (ovr_a) ovr_sa <= 1'b1;
    if (ovr_b) ovr_sb <= 1'b1;
  end

  adcsp_host_model i_host (.sys_clk_i(sys_clk), .cs_n_o(cs_n), .sclk_o(sclk), .din_o(din),
    .dout_a_i(dout_a), .oe_a_i(oe_a), .dout_b_i(dout_b), .oe_b_i(oe_b));
  adcsp_serial_port #(.RES_BITS(12)) i_dut (.sys_clk_i(sys_clk), .reset_i(reset),
    .cs_n_i(cs_n), .sclk_i(sclk), .din_i(din), .dout_o(dout_a), .dout_oe_o(oe_a),
    .chain_mode_i(mode), .cmp_above_i(cmp_a), .dac_code_o(dac_a), .track_o(track_a),
    .chan_sel_o(chan_a), .result_valid_o(valid_a), .result_ready_i(rdy),
    .result_data_o(data_a), .result_chan_o(rchan_a), .buf_ready_o(bufr_a), .overrun_o(ovr_a));
  adcsp_serial_port #(.RES_BITS(10)) i_dut_narrow (.sys_clk_i(sys_clk), .reset_i(reset),
    .cs_n_i(cs_n), .sclk_i(sclk), .din_i(din), .dout_o(dout_b), .dout_oe_o(oe_b),
    .chain_mode_i(mode), .cmp_above_i(cmp_b), .dac_code_o(dac_b), .track_o(track_b),
    .chan_sel_o(chan_b), .result_valid_o(valid_b), .result_ready_i(rdy),
    .result_data_o(data_b), .result_chan_o(rchan_b), .buf_ready_o(bufr_b), .overrun_o(ovr_b));

  // ****************************************
  // compare and closing tasks
  // ****************************************
  task automatic chk_frame(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    chk_frame({15'h0000, got}, {15'h0000, exp});
  endtask

  task automatic test_done;
    $display("checks=%0d mismatches=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic run(input logic req, input logic md, input int nfall, input int slot);
    logic [15:0] ga, gb;
    logic ok;
    logic [11:0] val;
    @(negedge sys_clk);
    mode = adcsp_mode_t'(md);
    v0 = vals[slot];
    v1 = ~vals[slot];
    val = prev ? v1 : v0;
    i_host.frame({2'b01, req, 13'h0A5A}, nfall, ga, gb, ok);
    if (nfall == 16) begin
      chk_frame(ga, {2'b00, prev, md, val});
      chk_frame(gb, {2'b00, prev, md, val[11:2], 2'b00});
      chk_flag(ok, 1'b1);
      exp_w[n_w] = {prev, val};
      n_w++;
      prev = req;
    end
    chk_flag(oe_a | oe_b, 1'b0);
    chk_flag(track_a & track_b, 1'b1);
  endtask

  task automatic drain(input int idx);
    int n;
    n = 0;
    while (valid_a !== 1'b1 && n < 50) begin
      @(negedge sys_clk);
      n++;
    end
    chk_flag(valid_a & valid_b, 1'b1);
    chk_frame({3'b000, rchan_a, data_a}, {3'b000, exp_w[idx]});
    chk_frame({5'h00, rchan_b, data_b}, {5'h00, exp_w[idx][12], exp_w[idx][11:2]});
    rdy = 1'b1;
    @(negedge sys_clk);
    rdy = 1'b0;
    @(negedge sys_clk);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    reset = 1'b1;
    rdy = 1'b0;
    mode = ADCSP_NORMAL;
    v0 = 12'h000;
    v1 = 12'h000;
    prev = 1'b0;
    n_w = 0;
    repeat (6) @(posedge sys_clk);
    @(negedge sys_clk);
    reset = 1'b0;
    repeat (4) @(negedge sys_clk);
    chk_flag(oe_a | oe_b | valid_a | valid_b, 1'b0);
    chk_flag(track_a & bufr_a & bufr_b, 1'b1);
    run(1'b1, 1'b0, 16, 0);
    run(1'b0, 1'b1, 16, 1);
    // third word finds both entries taken and is dropped, never stalled
    run(1'b1, 1'b0, 16, 2);
    chk_flag(ovr_sa & ovr_sb, 1'b1);
    chk_flag(bufr_a | bufr_b, 1'b0);
    drain(0);
    drain(1);
    chk_flag(valid_a | valid_b, 1'b0);
    run(1'b0, 1'b1, 8, 3);
    chk_flag(valid_a | valid_b, 1'b0);
    run(1'b0, 1'b1, 16, 3);
    drain(3);
    test_done;
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    test_done;
  end
endmodule
